// *** verilog/cqm_pkg.sv ***
`default_nettype none
package cqm_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned COEF_W = 18;
  localparam int unsigned COEF_FRAC = 16;
  // carrier modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_HALF = 2'h1;
  localparam logic [1:0] MODE_QUARTER = 2'h2;
  localparam logic [1:0] MODE_EIGHTH = 2'h3;
  // 0.707 in q2.16
  localparam logic signed [17:0] COEF_ONE = 18'sh10000;
  localparam logic signed [17:0] COEF_HALF_SQRT2 = 18'sh0B505;
  localparam logic [2:0] PHASE_RST = 3'h0;
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_NEG_BIT = 2;
  localparam int unsigned CTRL_CPLX_BIT = 3;
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } cqm_sample_t;
endpackage : cqm_pkg
`default_nettype wire

// *** verilog/cqm_modulator.sv ***
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - cosine and sine carriers are the same table read 90 degrees apart
// - complex mixing only at quarter or eighth rate; half rate falls back to real
// - negative-rotation bit flips the sign of the sine term
// - in complex mode both outputs rotate from either or both inputs; in real mode each output takes only its own input
// - complex bit couples both channels into one complex mixer at quarter or eighth rate only
// - quarter-rate carrier walks 0, +1, 0, -1
// - half-rate carrier alternates +1, -1, real mixing only
module cqm_modulator (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // sample stream
  input wire cqm_pkg::cqm_sample_t sample_in,
  output cqm_pkg::cqm_sample_t sample_out,
  output logic overrange_out
);
  typedef enum logic [1:0] {
    CQM_IDLE = 2'b01,
    CQM_DONE = 2'b10
  } cqm_bus_t;

  cqm_bus_t bus_q;
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [2:0] phase_q;
  logic ovr_sticky_q;
  cqm_pkg::cqm_sample_t out_q;
  logic ovr_q;

  wire logic [1:0] mode = ctrl_q[cqm_pkg::CTRL_MODE_LSB +: 2];
  wire logic neg_rot = ctrl_q[cqm_pkg::CTRL_NEG_BIT];
  wire logic cplx_req = ctrl_q[cqm_pkg::CTRL_CPLX_BIT];
  wire logic cplx_on = cplx_req && (mode == cqm_pkg::MODE_QUARTER ||
                                    mode == cqm_pkg::MODE_EIGHTH);
  wire logic req = avs_read_in || avs_write_in;
  wire logic hit_ctrl = avs_address_in == cqm_pkg::ADDR_CTRL;
  wire logic hit_stat = avs_address_in == cqm_pkg::ADDR_STAT;
  // writes land on the answer edge, the one at which waitrequest is low
  wire logic wr_ctrl = clk_en_in && avs_write_in && hit_ctrl && bus_q == CQM_DONE;
  wire logic clr_stat = clk_en_in && avs_write_in && hit_stat && bus_q == CQM_DONE;
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_q :
                             hit_stat ? {29'h0, cplx_on, ovr_sticky_q, ovr_q} : 32'h0;

  // sine table over eight phases; cosine is the sine two steps ahead
  function automatic logic signed [17:0] sin8(input logic [2:0] p);
    unique case (p)
      3'h0, 3'h4: sin8 = 18'sh0;
      3'h1, 3'h3: sin8 = cqm_pkg::COEF_HALF_SQRT2;
      3'h2: sin8 = cqm_pkg::COEF_ONE;
      3'h5, 3'h7: sin8 = -cqm_pkg::COEF_HALF_SQRT2;
      3'h6: sin8 = -cqm_pkg::COEF_ONE;
    endcase
  endfunction : sin8

  // eighth rate steps one phase, quarter rate two, giving 0,+1,0,-1
  wire logic [2:0] step = (mode == cqm_pkg::MODE_EIGHTH) ? 3'h1 : 3'h2;
  wire logic signed [17:0] sin_raw = sin8(phase_q);
  wire logic signed [17:0] cos_raw = sin8(3'(phase_q + 3'h2));
  // half rate alternates +1,-1 on the cosine path only
  wire logic signed [17:0] half_c = phase_q[2] ? -cqm_pkg::COEF_ONE : cqm_pkg::COEF_ONE;
  wire logic signed [17:0] cos_c = (mode == cqm_pkg::MODE_OFF) ? cqm_pkg::COEF_ONE :
                                   (mode == cqm_pkg::MODE_HALF) ? half_c : cos_raw;
  wire logic signed [17:0] sin_c = neg_rot ? -sin_raw : sin_raw;
  wire logic signed [15:0] xi = sample_in.re;
  wire logic signed [15:0] xq = sample_in.im;
  wire logic signed [35:0] p_ic = 36'(xi * cos_c);
  wire logic signed [35:0] p_qc = 36'(xq * cos_c);
  wire logic signed [35:0] p_is = 36'(xi * sin_c);
  wire logic signed [35:0] p_qs = 36'(xq * sin_c);
  // complex: couple both paths; real: each channel mixed by its own cosine
  wire logic signed [36:0] acc_re = cplx_on ? 37'(p_ic - p_qs) : 37'(p_ic);
  wire logic signed [36:0] acc_im = cplx_on ? 37'(p_is + p_qc) : 37'(p_qc);
  wire logic signed [20:0] sh_re = acc_re[36:16];
  wire logic signed [20:0] sh_im = acc_im[36:16];

  function automatic logic [16:0] sat16(input logic signed [20:0] v);
    if (v > 21'sd32767) begin
      sat16 = {1'b1, 16'h7FFF};
    end else if (v < -21'sd32768) begin
      sat16 = {1'b1, 16'h8000};
    end else begin
      sat16 = {1'b0, v[15:0]};
    end
  endfunction : sat16

  wire logic [16:0] s_re = sat16(sh_re);
  wire logic [16:0] s_im = sat16(sh_im);
  wire logic ovr_now = s_re[16] | s_im[16];

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_q <= cqm_pkg::PHASE_RST;
      out_q <= '0;
      ovr_q <= 1'b0;
    end else if (clk_en_in) begin
      // a control write restarts the carrier so quarter rate never lands on odd phases
      if (wr_ctrl) begin
        phase_q <= cqm_pkg::PHASE_RST;
      end else begin
        phase_q <= (mode == cqm_pkg::MODE_HALF) ? 3'(phase_q + 3'h4) : 3'(phase_q + step);
      end
      out_q.re <= s_re[15:0];
      out_q.im <= s_im[15:0];
      ovr_q <= ovr_now;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= cqm_pkg::CTRL_RST;
      ovr_sticky_q <= 1'b0;
      bus_q <= CQM_IDLE;
      rdata_q <= 32'h0;
    end else if (clk_en_in) begin
      if (wr_ctrl) begin
        ctrl_q <= {28'h0, avs_writedata_in[3:0]};
      end
      // set wins over clear
      if (ovr_now) begin
        ovr_sticky_q <= 1'b1;
      end else if (clr_stat && avs_writedata_in[1]) begin
        ovr_sticky_q <= 1'b0;
      end
      unique case (bus_q)
        CQM_IDLE: if (req) begin
          bus_q <= CQM_DONE;
          rdata_q <= rd_mux;
        end
        CQM_DONE: bus_q <= CQM_IDLE;
      endcase
    end
  end

  assign sample_out = out_q;
  assign overrange_out = ovr_q;
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = !(bus_q == CQM_DONE);

  localparam logic signed [17:0] COEF_ONE_S = cqm_pkg::COEF_ONE;

  quarter_seq_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && !wr_ctrl && mode == cqm_pkg::MODE_QUARTER && $stable(mode)) |=>
    (phase_q == 3'($past(phase_q) + 3'h2)))
    else $error("quarter carrier step wrong");
  half_alt_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (mode == cqm_pkg::MODE_HALF) |-> (cos_c == COEF_ONE_S || cos_c == -COEF_ONE_S))
    else $error("half carrier not +-1");
  quad_pair_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (cos_raw == 18'sh0) |-> (sin_raw != 18'sh0))
    else $error("carriers not in quadrature");
  no_half_cplx_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (mode == cqm_pkg::MODE_HALF || mode == cqm_pkg::MODE_OFF) |-> !cplx_on)
    else $error("complex mix at illegal rate");
  sine_sign_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    neg_rot |-> (sin_c == -sin_raw))
    else $error("sine sign not flipped");
  sat_out_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && sh_re > 21'sd32767) |=> (sample_out.re == 16'h7FFF && overrange_out))
    else $error("real output not saturated");
  coupled_mix_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && cplx_on && xi == 16'sh0 && !ovr_now) |=>
    (sample_out.re == $past(s_re[15:0]) && sample_out.im == $past(s_im[15:0])))
    else $error("imaginary-only input lost");
  cplx_bit_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !cplx_req |-> (acc_re == 37'(p_ic)))
    else $error("paths coupled while complex off");
  mix_eq_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    cplx_on |-> (acc_im == 37'(p_is + p_qc)))
    else $error("imaginary mix equation wrong");
  bus_ans_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && req && bus_q == CQM_IDLE) |=> !avs_waitrequest_out)
    else $error("bus answer late");

  // clock enable low holds every register
  freeze_state_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !clk_en_in |=> ($stable(phase_q) && $stable(ctrl_q) && $stable(ovr_sticky_q)))
    else $error("state moved with enable low");

  freeze_out_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !clk_en_in |=> ($stable(sample_out) && $stable(overrange_out)))
    else $error("outputs moved with enable low");

  // carrier generation
  phase_rst_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    wr_ctrl |=> (phase_q == cqm_pkg::PHASE_RST))
    else $error("carrier not restarted by control write");

  quarter_even_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (mode == cqm_pkg::MODE_QUARTER) |->
    (!phase_q[0] && ((cos_raw == 18'sh0) != (sin_raw == 18'sh0))))
    else $error("quarter carrier off its four points");

  quarter_unit_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (mode == cqm_pkg::MODE_QUARTER) |->
    (sin_raw == 18'sh0 || sin_raw == COEF_ONE_S || sin_raw == -COEF_ONE_S))
    else $error("quarter carrier value not 0 or 1");

  eighth_step_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && mode == cqm_pkg::MODE_EIGHTH && !wr_ctrl) |=>
    (phase_q == 3'($past(phase_q) + 3'h1)))
    else $error("eighth carrier step wrong");

  half_flip_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && mode == cqm_pkg::MODE_HALF && !wr_ctrl) |=>
    (half_c == -$past(half_c)))
    else $error("half carrier did not alternate");

  quad_peak_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (sin_raw == COEF_ONE_S || sin_raw == -COEF_ONE_S) |-> (cos_raw == 18'sh0))
    else $error("cosine not zero at sine peak");

  // mixer
  off_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && mode == cqm_pkg::MODE_OFF) |=> (sample_out == $past(sample_in)))
    else $error("carrier off does not pass data");

  real_split_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && !cplx_on && xi == 16'sh0) |=> (sample_out.re == 16'sh0))
    else $error("real mode couples channels");

  imag_reach_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && cplx_on && xi == 16'sh0 && (xq > 16'sd3 || xq < -16'sd3) &&
    sin_c != 18'sh0) |=> (sample_out.re != 16'sh0))
    else $error("imaginary input missing from real output");

  real_reach_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && cplx_on && xq == 16'sh0 && (xi > 16'sd3 || xi < -16'sd3) &&
    sin_c != 18'sh0) |=> (sample_out.im != 16'sh0))
    else $error("real input missing from imaginary output");

  rot_neg_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && cplx_on && neg_rot && xq == 16'sh0 && xi > 16'sd3 &&
    sin_raw > 18'sh0) |=> (sample_out.im < 16'sh0))
    else $error("negative rotation has wrong sine sign");

  rot_pos_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && cplx_on && !neg_rot && xq == 16'sh0 && xi > 16'sd3 &&
    sin_raw > 18'sh0) |=> (sample_out.im > 16'sh0))
    else $error("positive rotation has wrong sine sign");

  sat_low_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && sh_im < -21'sd32768) |=>
    (sample_out.im == 16'sh8000 && overrange_out))
    else $error("imaginary output not saturated low");

  ovr_pin_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && ovr_now) |=> (overrange_out && ovr_sticky_q))
    else $error("overrange not flagged");

  no_ovr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && !ovr_now) |=> !overrange_out)
    else $error("overrange flagged without cause");

  // status and bus
  sticky_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && ovr_sticky_q && !clr_stat) |=> ovr_sticky_q)
    else $error("sticky overrange lost");

  sticky_clr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clr_stat && avs_writedata_in[1] && !ovr_now) |=> !ovr_sticky_q)
    else $error("sticky overrange not cleared");

  wait_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && !avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");

  rd_ctrl_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && avs_read_in && hit_ctrl && bus_q == CQM_IDLE) |=>
    (avs_readdata_out == $past(ctrl_q)))
    else $error("control read data wrong");

  rd_stat_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (clk_en_in && avs_read_in && hit_stat && bus_q == CQM_IDLE) |=>
    (avs_readdata_out[2:0] == $past({cplx_on, ovr_sticky_q, ovr_q})))
    else $error("status read data wrong");

  ctrl_wr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    wr_ctrl |=> (ctrl_q[3:0] == $past(avs_writedata_in[3:0])))
    else $error("control write lost");

  ctrl_top_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    ctrl_q[31:4] == 28'h0)
    else $error("unused control bits set");

  cplx_q4_c: cover property (@(posedge sys_clk_in) cplx_on && mode == cqm_pkg::MODE_QUARTER);
  cplx_q8_c: cover property (@(posedge sys_clk_in) cplx_on && mode == cqm_pkg::MODE_EIGHTH && neg_rot);
  ovr_c: cover property (@(posedge sys_clk_in) ovr_now);
  half_cplx_c: cover property (@(posedge sys_clk_in) mode == cqm_pkg::MODE_HALF && cplx_req);
  freeze_c: cover property (@(posedge sys_clk_in) !clk_en_in && mode == cqm_pkg::MODE_QUARTER);
endmodule : cqm_modulator
`default_nettype wire

// *** verif/cqm_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module cqm_source (
  // clock and request
  input wire logic sys_clk_in,
  input wire logic hot_in,
  input wire cqm_pkg::cqm_sample_t want_in,
  // samples to the modulator
  output cqm_pkg::cqm_sample_t sample_out
);
  localparam logic signed [15:0] LIM = 16'sh5A82;
  function automatic logic signed [15:0] cap(input logic signed [15:0] v);
    return (v > LIM) ? LIM : ((v < -LIM) ? -LIM : v);
  endfunction : cap
  initial sample_out = '0;
  // stays 3 dB under full scale unless overrange is asked for
  always @(posedge sys_clk_in) begin
    sample_out <= hot_in ? want_in : '{re: cap(want_in.re), im: cap(want_in.im)};
  end
endmodule : cqm_source
`default_nettype wire

// *** verif/test_complex_quadrature_modulator.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_complex_quadrature_modulator;
  localparam int SN [8] = '{18'sh0, 18'sh0B505, 18'sh10000, 18'sh0B505, 18'sh0,
    -18'sh0B505, -18'sh10000, -18'sh0B505};
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, hot = 1'b0, en = 1'b1, ovr, wt;
  logic [7:0] ov = 8'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdv, rq;
  cqm_pkg::cqm_sample_t want = '0, smp, so, s [8];
  int n_fail = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  cqm_source i_cqm_source (.sys_clk_in(clk), .hot_in(hot), .want_in(want), .sample_out(smp));
  cqm_modulator i_cqm_modulator (.sys_clk_in(clk), .rstn_in(rstn), .clk_en_in(en),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_readdata_out(rq), .avs_waitrequest_out(wt), .sample_in(smp), .sample_out(so),
    .overrange_out(ovr));
  task automatic close_out;
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic near(input logic signed [15:0] g, input int e);
    return !$isunknown(g) && (g - e <= 2) && (e - g <= 2);
  endfunction : near
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    rdv = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic grab(input logic [31:0] c, input int i, input int q, input logic h);
    bus(1'b1, cqm_pkg::ADDR_CTRL, c);
    want <= '{re: 16'(i), im: 16'(q)};
    hot <= h;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      s[k] = so;
      ov[k] = ovr;
    end
  endtask : grab
  function automatic int mx(input int i, input int q, input int p, input bit ng, input bit im);
    int c, g;
    c = SN[(p + 2) % 8];
    g = ng ? -SN[p % 8] : SN[p % 8];
    return im ? ((i * g) >>> 16) + ((q * c) >>> 16) : ((i * c) >>> 16) - ((q * g) >>> 16);
  endfunction : mx
  task automatic cplx(input logic [1:0] m, input bit ng, input int i, input int q);
    int st, p0;
    st = (m == cqm_pkg::MODE_QUARTER) ? 2 : 1;
    p0 = -1;
    grab({28'h0, 1'b1, ng, m}, i, q, 1'b0);
    for (int p = 7; p >= 0; p--) begin
      if (near(s[0].re, mx(i, q, p, ng, 0)) && near(s[0].im, mx(i, q, p, ng, 1))) p0 = p;
    end
    chk(p0 >= 0, "no carrier phase fits");
    for (int k = 1; k < 8; k++) begin
      chk(near(s[k].re, mx(i, q, p0 + k * st, ng, 0)), "complex re wrong");
      chk(near(s[k].im, mx(i, q, p0 + k * st, ng, 1)), "complex im wrong");
    end
    chk(ov === 8'h0, "overrange without cause");
  endtask : cplx
  task automatic t_regs;
    bus(1'b0, cqm_pkg::ADDR_CTRL, 32'h0);
    chk(rdv === cqm_pkg::CTRL_RST, "ctrl reset value");
    bus(1'b1, cqm_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, cqm_pkg::ADDR_CTRL, 32'h0);
    chk(rdv === 32'h0000_000F, "ctrl readback");
    bus(1'b0, 4'h8, 32'h0);
    chk(rdv === 32'h0, "unmapped read");
  endtask : t_regs
  task automatic t_off_half;
    int c;
    grab(32'h0, 16'sh04D2, -16'sh08AE, 1'b0);
    chk(so.re === 16'sh04D2 && so.im === -16'sh08AE, "carrier off changes data");
    grab({28'h0, 2'h2, cqm_pkg::MODE_HALF}, 16'sh03E8, -16'sh0BB8, 1'b0);
    c = (s[0].re < 0) ? -1 : 1;
    for (int k = 0; k < 8; k++) begin
      chk(near(s[k].re, (k % 2 ? -c : c) * 16'sh03E8), "half rate re");
      chk(near(s[k].im, (k % 2 ? c : -c) * 16'sh0BB8), "half rate im");
    end
  endtask : t_off_half
  task automatic t_cplx;
    for (int n = 0; n < 4; n++) begin
      cplx(n[0] ? cqm_pkg::MODE_EIGHTH : cqm_pkg::MODE_QUARTER, n[1], 16'sh2000, 16'sh0);
      cplx(n[0] ? cqm_pkg::MODE_EIGHTH : cqm_pkg::MODE_QUARTER, n[1], 16'sh0, 16'sh2000);
      cplx(n[0] ? cqm_pkg::MODE_EIGHTH : cqm_pkg::MODE_QUARTER, n[1], 16'sh2000, -16'sh1000);
    end
  endtask : t_cplx
  task automatic t_freeze;
    cqm_pkg::cqm_sample_t held;
    grab({28'h0, 2'h2, cqm_pkg::MODE_QUARTER}, 16'sh1000, 16'sh0800, 1'b0);
    en <= 1'b0;
    @(posedge clk);
    held = so;
    repeat (4) @(posedge clk);
    chk(so === held, "output moved with enable low");
    en <= 1'b1;
    repeat (2) @(posedge clk);
    chk(so !== held, "output frozen after enable rose");
  endtask : t_freeze
  task automatic t_sat;
    logic hit;
    grab({28'h0, 2'h2, cqm_pkg::MODE_EIGHTH}, 16'sh7FFF, 16'sh7FFF, 1'b1);
    hit = 1'b0;
    for (int k = 0; k < 8; k++) hit |= (s[k].im === 16'sh7FFF);
    chk(hit, "no saturation");
    chk(ov !== 8'h0, "overrange pin never rose");
    bus(1'b0, cqm_pkg::ADDR_STAT, 32'h0);
    chk(rdv[1] === 1'b1, "sticky overrange unset");
    chk(rdv[2] === 1'b1, "complex status not shown");
    want <= '0;
    hot <= 1'b0;
    bus(1'b1, cqm_pkg::ADDR_STAT, 32'h0000_0002);
    bus(1'b0, cqm_pkg::ADDR_STAT, 32'h0);
    chk(rdv[1] === 1'b0, "sticky overrange not cleared");
  endtask : t_sat
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_off_half();
    t_cplx();
    t_freeze();
    t_sat();
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule : test_complex_quadrature_modulator
`default_nettype wire
